// ==== mcu_address_generation.sv ====
// Program counter and RAM/table address generation for a 4-bit core.
// Assumes instr_step pulses once per executed instruction word, with instr_kind,
// imm_field and instr_word valid in that cycle; table ROM answers in the same cycle that table_req is high.
`timescale 1ns/100ps
`default_nettype none

module mcu_address_generation
  import agen_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic instr_step,
  input wire logic [3:0] instr_kind,
  input wire logic [PC_W-1:0] imm_field,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [1:0] w_ptr,
  input wire logic [NIB_W-1:0] x_ptr,
  input wire logic [NIB_W-1:0] y_ptr,
  input wire logic [NIB_W-1:0] acc_in,
  input wire logic [NIB_W-1:0] aux_in,
  input wire logic [WORD_W-1:0] table_word,
  output logic [PC_W-1:0] pc,
  output logic [RAM_W-1:0] ram_addr,
  output logic ram_addr_valid,
  output logic [PC_W-1:0] table_addr,
  output logic table_req,
  output logic [NIB_W-1:0] acc_out,
  output logic [NIB_W-1:0] aux_out,
  output logic acc_load,
  output logic [NIB_W-1:0] port1_out,
  output logic [NIB_W-1:0] port2_out,
  output logic port_load,
  output logic busy
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    agen_state_e st;
    logic [PC_W-1:0] pc;
    logic [RAM_W-1:0] ram_addr;
    logic ram_valid;
    logic [PC_W-1:0] tbl_addr;
    logic tbl_req;
    logic [NIB_W-1:0] acc;
    logic [NIB_W-1:0] aux;
    logic acc_load;
    logic [NIB_W-1:0] p1;
    logic [NIB_W-1:0] p2;
    logic port_load;
    logic busy;
  } agen_s;

  localparam agen_s AGEN_RESET = '{
    st: ST_RUN, pc: PC_RESET, ram_addr: '0, ram_valid: 1'b0,
    tbl_addr: PC_RESET, tbl_req: 1'b0, acc: NIB_RESET, aux: NIB_RESET,
    acc_load: 1'b0, p1: NIB_RESET, p2: NIB_RESET, port_load: 1'b0, busy: 1'b0};

  agen_s s_q;
  agen_s s_d;

  // Shared by table jump and table fetch so both see the same address
  function automatic logic [PC_W-1:0] table_dest(input logic [NIB_W-1:0] imm,
                                                 input logic [NIB_W-1:0] aux,
                                                 input logic [NIB_W-1:0] acc);
    table_dest = {2'b00, imm, aux, acc};
  endfunction : table_dest

  logic [PC_W-1:0] pc_inc;
  assign pc_inc = s_q.pc + PC_STEP;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ram_valid = 1'b0;
    s_d.tbl_req = 1'b0;
    s_d.acc_load = 1'b0;
    s_d.port_load = 1'b0;
    case (s_q.st)
      ST_RUN: begin
        if (instr_step) begin
          s_d.pc = pc_inc;
          case (instr_kind)
            K_LONG: s_d.pc = imm_field;
            // Page bits taken from the advanced PC, so the last word of a page
            // branches within the next page
            K_PAGE: s_d.pc = {pc_inc[PC_W-1:PAGE_LO_W], imm_field[PAGE_LO_W-1:0]};
            K_ZERO: s_d.pc = {{(PC_W-ZERO_PAGE_W){1'b0}}, imm_field[ZERO_PAGE_W-1:0]};
            K_TABLE_JMP: s_d.pc = table_dest(imm_field[NIB_W-1:0], aux_in, acc_in);
            K_TABLE_FETCH: begin
              s_d.tbl_addr = table_dest(imm_field[NIB_W-1:0], aux_in, acc_in);
              s_d.tbl_req = 1'b1;
              s_d.st = ST_FETCH;
            end
            K_RAM_IND: begin
              s_d.ram_addr = {w_ptr, x_ptr, y_ptr};
              s_d.ram_valid = 1'b1;
            end
            K_RAM_DIR: s_d.st = ST_DIR2;
            K_SCRATCH: begin
              s_d.ram_addr = SCRATCH_BASE | {6'h00, imm_field[NIB_W-1:0]};
              s_d.ram_valid = 1'b1;
            end
            default: ;
          endcase
        end
      end
      ST_DIR2: begin
        if (instr_step) begin
          s_d.pc = pc_inc;
          s_d.ram_addr = instr_word;
          s_d.ram_valid = 1'b1;
          s_d.st = ST_RUN;
        end
      end
      ST_FETCH: begin
        // Steps are ignored here; the core stalls on busy
        if (table_word[TBL_ACC_BIT]) begin
          s_d.acc = table_word[3:0];
          s_d.aux = table_word[7:4];
          s_d.acc_load = 1'b1;
        end
        if (table_word[TBL_PORT_BIT]) begin
          s_d.p1 = table_word[3:0];
          s_d.p2 = table_word[7:4];
          s_d.port_load = 1'b1;
        end
        s_d.st = ST_RUN;
      end
      default: s_d.st = ST_RUN;
    endcase
    // Registered so the output comes straight from a flop
    s_d.busy = (s_d.st != ST_RUN);
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      s_q <= AGEN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pc = s_q.pc;
  assign ram_addr = s_q.ram_addr;
  assign ram_addr_valid = s_q.ram_valid;
  assign table_addr = s_q.tbl_addr;
  assign table_req = s_q.tbl_req;
  assign acc_out = s_q.acc;
  assign aux_out = s_q.aux;
  assign acc_load = s_q.acc_load;
  assign port1_out = s_q.p1;
  assign port2_out = s_q.p2;
  assign port_load = s_q.port_load;
  assign busy = s_q.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic run_step;
  assign run_step = instr_step && (s_q.st == ST_RUN);

  sequence s_fetch_issue;
    run_step && instr_kind == K_TABLE_FETCH;
  endsequence

  sequence s_fetch_answer;
    ##1 table_req && s_q.st == ST_FETCH;
  endsequence

  property p_ind;
    @(posedge mclk) disable iff (!rst_q)
    run_step && instr_kind == K_RAM_IND |=> ram_addr_valid
      && ram_addr == {$past(w_ptr), $past(x_ptr), $past(y_ptr)};
  endproperty
  a_ind: assert property (p_ind) else $error("indirect address wrong");

  sequence s_dir_second;
    instr_step && s_q.st == ST_DIR2;
  endsequence

  property p_dir_wait;
    @(posedge mclk) disable iff (!rst_q)
    run_step && instr_kind == K_RAM_DIR |=> busy && !ram_addr_valid && pc == $past(pc_inc);
  endproperty
  a_dir_wait: assert property (p_dir_wait) else $error("direct first word wrong");

  property p_dir;
    @(posedge mclk) disable iff (!rst_q)
    s_dir_second |=> ram_addr_valid && ram_addr == $past(instr_word) && pc == $past(pc_inc);
  endproperty
  a_dir: assert property (p_dir) else $error("direct address wrong");

  property p_scratch;
    @(posedge mclk) disable iff (!rst_q)
    run_step && instr_kind == K_SCRATCH |=> ram_addr_valid
      && ram_addr >= SCRATCH_BASE && ram_addr <= (SCRATCH_BASE + 10'h00F)
      && ram_addr[NIB_W-1:0] == $past(imm_field[NIB_W-1:0]);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch address out of range");

  property p_long;
    @(posedge mclk) disable iff (!rst_q)
    run_step && instr_kind == K_LONG |=> pc == $past(imm_field);
  endproperty
  a_long: assert property (p_long) else $error("long jump target wrong");

  property p_page;
    @(posedge mclk) disable iff (!rst_q)
    run_step && instr_kind == K_PAGE |=>
      pc == {$past(pc_inc[PC_W-1:PAGE_LO_W]), $past(imm_field[PAGE_LO_W-1:0])};
  endproperty
  a_page: assert property (p_page) else $error("page jump target wrong");

  property p_zero;
    @(posedge mclk) disable iff (!rst_q)
    run_step && instr_kind == K_ZERO |=> pc[PC_W-1:ZERO_PAGE_W] == 8'h00
      && pc[ZERO_PAGE_W-1:0] == $past(imm_field[ZERO_PAGE_W-1:0]);
  endproperty
  a_zero: assert property (p_zero) else $error("zero-page target wrong");

  property p_fetch;
    @(posedge mclk) disable iff (!rst_q)
    s_fetch_issue |-> s_fetch_answer ##1 (acc_load == $past(table_word[TBL_ACC_BIT])
      && port_load == $past(table_word[TBL_PORT_BIT]) && !busy);
  endproperty
  a_fetch: assert property (p_fetch) else $error("table fetch loads wrong");

  property p_fetch_pc;
    @(posedge mclk) disable iff (!rst_q)
    s_fetch_issue |=> pc == $past(pc_inc) ##1 $stable(pc);
  endproperty
  a_fetch_pc: assert property (p_fetch_pc) else $error("table fetch moved the pc");

  property p_seq;
    @(posedge mclk) disable iff (!rst_q)
    run_step && instr_kind == K_SEQ |=> pc == $past(pc_inc);
  endproperty
  a_seq: assert property (p_seq) else $error("pc did not advance by one");

  property p_hold;
    @(posedge mclk) disable iff (!rst_q)
    !instr_step && s_q.st == ST_RUN |=> $stable(pc);
  endproperty
  a_hold: assert property (p_hold) else $error("pc moved without a step");

endmodule : mcu_address_generation

`default_nettype wire

// ==== agen_pkg.sv ====
// Constants, state and instruction-class encodings for the address generator.
// Assumes a separate decoder classifies each instruction word and supplies its immediate.
package agen_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 14;
  localparam int RAM_W = 10;
  localparam int WORD_W = 10;
  localparam int PAGE_LO_W = 8;
  localparam int ZERO_PAGE_W = 6;
  localparam int NIB_W = 4;

  // ----------------------------------------------------------------
  // Addresses, field positions, reset values
  // ----------------------------------------------------------------
  localparam logic [RAM_W-1:0] SCRATCH_BASE = 10'h040;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 14'h0001;
  localparam int TBL_ACC_BIT = 8;
  localparam int TBL_PORT_BIT = 9;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    K_SEQ = 4'h0,
    K_LONG = 4'h1,
    K_PAGE = 4'h2,
    K_ZERO = 4'h3,
    K_TABLE_JMP = 4'h4,
    K_TABLE_FETCH = 4'h5,
    K_RAM_IND = 4'h6,
    K_RAM_DIR = 4'h7,
    K_SCRATCH = 4'h8
  } instr_kind_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DIR2 = 2'b01,
    ST_FETCH = 2'b10
  } agen_state_e;

endpackage : agen_pkg

// ==== agen_notes_unused.sv ====
`timescale 1ns/100ps

// ==== testbench.sv ====
// Self-checking bench for the address generator: branches, RAM modes, table work.
// Assumes the generator module and its package are compiled first.
`timescale 1ns/100ps
`default_nettype none

module testbench
  import agen_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic instr_step = 1'b0;
  logic [3:0] instr_kind = 4'h0;
  logic [PC_W-1:0] imm_field = 14'h0000;
  logic [WORD_W-1:0] instr_word = 10'h000;
  logic [1:0] w_ptr = 2'h0;
  logic [NIB_W-1:0] x_ptr = 4'h0;
  logic [NIB_W-1:0] y_ptr = 4'h0;
  logic [NIB_W-1:0] acc_in = 4'h0;
  logic [NIB_W-1:0] aux_in = 4'h0;
  logic [WORD_W-1:0] table_word = 10'h000;
  logic [PC_W-1:0] pc, table_addr;
  logic [RAM_W-1:0] ram_addr;
  logic ram_addr_valid, table_req, acc_load, port_load, busy;
  logic [NIB_W-1:0] acc_out, aux_out, port1_out, port2_out;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [PC_W-1:0] exp_pc;

  mcu_address_generation i_dut (.mclk(mclk), .nrst(nrst), .instr_step(instr_step),
    .instr_kind(instr_kind), .imm_field(imm_field), .instr_word(instr_word), .w_ptr(w_ptr),
    .x_ptr(x_ptr), .y_ptr(y_ptr), .acc_in(acc_in), .aux_in(aux_in), .table_word(table_word),
    .pc(pc), .ram_addr(ram_addr), .ram_addr_valid(ram_addr_valid), .table_addr(table_addr),
    .table_req(table_req), .acc_out(acc_out), .aux_out(aux_out), .acc_load(acc_load),
    .port1_out(port1_out), .port2_out(port2_out), .port_load(port_load), .busy(busy));

  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Wide enough for every address and flag of the block
  task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Returns at the falling edge after the taking edge, so outputs have settled
  task automatic step(input logic [3:0] k, input logic [13:0] imm);
    @(negedge mclk);
    instr_step = 1'b1;
    instr_kind = k;
    imm_field = imm;
    @(negedge mclk);
    instr_step = 1'b0;
    exp_pc = exp_pc + PC_STEP;
  endtask : step

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_branches();
    step(K_SEQ, 14'h3FFF);
    chk(pc, exp_pc, "seq pc");
    step(K_LONG, 14'h20FF);
    chk(pc, 14'h20FF, "long pc");
    step(K_PAGE, 14'h3F34);
    chk(pc, 14'h2134, "page end pc");
    step(K_PAGE, 14'h0056);
    chk(pc, 14'h2156, "page pc");
    step(K_ZERO, 14'h3FFF);
    chk(pc, 14'h003F, "zero pc");
    acc_in = 4'h3;
    aux_in = 4'hC;
    step(K_TABLE_JMP, 14'h3FF9);
    chk(pc, 14'h09C3, "table jump pc");
    exp_pc = pc;
  endtask : t_branches

  task automatic t_ram();
    w_ptr = 2'h2;
    x_ptr = 4'h5;
    y_ptr = 4'hA;
    step(K_RAM_IND, 14'h0000);
    chk(14'(ram_addr), 14'h025A, "ind addr");
    chk(14'(ram_addr_valid), 14'h0001, "ind valid");
    instr_word = 10'h3C5;
    step(K_RAM_DIR, 14'h0000);
    chk(14'(busy), 14'h0001, "dir busy");
    chk(pc, exp_pc, "dir pc1");
    step(K_SEQ, 14'h0000);
    chk(14'(ram_addr), 14'h03C5, "dir addr");
    chk(14'(ram_addr_valid), 14'h0001, "dir valid");
    chk(pc, exp_pc, "dir pc2");
    step(K_SCRATCH, 14'h000F);
    chk(14'(ram_addr), 14'h004F, "scratch top");
    step(K_SCRATCH, 14'h3FF0);
    chk(14'(ram_addr), 14'h0040, "scratch base");
    @(negedge mclk);
    chk(14'(ram_addr_valid), 14'h0000, "valid drops");
    chk(14'(ram_addr), 14'h0040, "addr holds");
  endtask : t_ram

  // Every combination of the two flag bits, each with fresh data so holds show
  task automatic t_fetch();
    logic [7:0] data;
    logic [7:0] acc_exp;
    logic [7:0] port_exp;
    acc_exp = 8'h00;
    port_exp = 8'h00;
    acc_in = 4'h3;
    aux_in = 4'hC;
    for (int i = 0; i < 4; i++) begin
      data = 8'h1E + 8'(i) * 8'h22;
      table_word = {2'(i), data};
      step(K_TABLE_FETCH, 14'h0006);
      chk(14'(table_req), 14'h0001, "table req");
      chk(table_addr, 14'h06C3, "table addr");
      chk(pc, exp_pc, "fetch pc");
      @(negedge mclk);
      if (i[0]) acc_exp = data;
      if (i[1]) port_exp = data;
      chk(14'(acc_load), 14'(i[0]), "acc load");
      chk(14'(port_load), 14'(i[1]), "port load");
      chk(14'({aux_out, acc_out}), 14'(acc_exp), "acc pair");
      chk(14'({port2_out, port1_out}), 14'(port_exp), "ports");
      chk(14'(busy), 14'h0000, "fetch done");
      chk(pc, exp_pc, "fetch pc hold");
    end
  endtask : t_fetch

  // ----------------------------------------------------------------
  // Sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    exp_pc = PC_RESET;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    chk(pc, PC_RESET, "reset pc");
    t_branches();
    t_ram();
    t_fetch();
    summarize();
  end

endmodule : testbench

`default_nettype wire
